/* File: design/tpc_map.svh */
// Register indices, reset values and field positions of the pattern controller
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// Register indices; byte address on APB is four times the index
`define IDX_MODE          16'hFFA0
`define IDX_TRIG          16'hFFA1
`define IDX_EN_HIGH       16'hFFA2
`define IDX_EN_LOW        16'hFFA3
`define IDX_STAGE_HIGH    16'hFFA4
`define IDX_STAGE_LOW     16'hFFA5
`define IDX_STAGE_HIGH_G2 16'hFFA6
`define IDX_STAGE_LOW_G0  16'hFFA7
`define IDX_PLOW_DIR      16'hFFD1
`define IDX_PLOW_LATCH    16'hFFD3
`define IDX_PHIGH_DIR     16'hFFD4
`define IDX_PHIGH_LATCH   16'hFFD6

// Reset values
`define RST_MODE          8'hF0
`define RST_TRIG          8'hFF
`define RST_ZERO          8'h00

// Read values of reserved or write-only locations
`define RD_ONES           8'hFF
`define NIB_ONES          4'hF

// Fields: trigger select is two bits per group, mode has one bit per group
`define TRIG_FIELD_W      2
`define MODE_NOV_MSB      3
`define PATTERN_HOLE      6

`endif

/* File: design/tpc_pkg.sv */
// Types of the timing pattern output controller
package tpc_pkg;

   typedef enum logic [0:0] {
      PH_WAIT = 1'b0,
      PH_DONE = 1'b1
   } apb_phase_e;

   typedef struct packed {
      logic [1:0] standby_sync;
      logic [7:0] mode;
      logic [7:0] trig;
      logic [7:0] en_high;
      logic [7:0] en_low;
      logic [7:0] stage_high;
      logic [7:0] stage_low;
      logic [7:0] plow_dir;
      logic [7:0] plow_latch;
      logic [7:0] phigh_dir;
      logic [7:0] phigh_latch;
      apb_phase_e phase;
      logic       pready;
      logic       pslverr;
      logic [31:0] prdata;
      logic [7:0] plow_oe;
      logic [7:0] phigh_oe;
   } tpc_state_s;

endpackage : tpc_pkg

/* File: design/timing_pattern_output.sv */
// Timing pattern output controller with APB register slave
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "tpc_map.svh"

// How it works
// [R1] Four 4-bit output groups, 3 down to 0, each acting on its own.
// [R2] Pattern bit 14 has no pin, so at most 15 bits reach the outside.
// [R3] Each bit has its own enable; only enabled bits are transferred.
// [R4] Each group picks its trigger from compare-match pulses of four timer channels.
// [R5] Non-overlap mode clears falling bits first, raising bits on the later event.
// [R6] Both port direction registers are 8 bits wide and write-only.
// [R7] Software sets direction bits of pattern pins to one before use.
// [R8] High port direction is 8-bit write-only; high port carries bits 15, 13..8.
// [R9] Low port latch holds groups 0/1 output, high port latch groups 2/3.
// [R10] Low port latch bits enabled for pattern output ignore CPU writes.
// [R11] High port latch bits enabled for pattern output ignore CPU writes.
// [R12] On the selected event, staged low bits copy into the low port latch.
// [R13] Staged low register clears on reset and hardware standby.
// [R14] Shared trigger: groups 1/0 staged byte at one address, group 1 upper.
// [R15] Shared trigger: companion address is reserved, ignores writes, reads ones.
// [R16] Different triggers: group 0 nibble at companion address, group 1 stays.
// [R17] Groups 3/2 alias the same way; with different triggers group 2 moves.
// [R18] Disabled bits are not transferred and their pin keeps its value.
// [R19] Trigger codes 00, 01, 10 select timer channels 0, 1, 2.
// [R20] Transfer lands the cycle after the compare-match pulse, whole group together.
// [R21] Groups sharing a trigger update in the same cycle.
module timing_pattern_output (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Timer compare-match pulses, one per channel, same clock
   input  wire logic [3:0]  cmp_a,
   input  wire logic [3:0]  cmp_b,
   // Hardware standby pin
   input  wire logic        hw_standby,
   // Port pins
   output logic      [7:0]  port_low_out,
   output logic      [7:0]  port_low_oe,
   output logic      [7:0]  port_high_out,
   output logic      [7:0]  port_high_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   tpc_pkg::tpc_state_s s_q;
   tpc_pkg::tpc_state_s s_d;

   logic        [3:0]  fire_a;
   logic        [3:0]  fire_b;
   logic        [15:0] enable_all;
   logic        [15:0] stage_all;
   logic        [15:0] latch_all;
   logic        [15:0] latch_next;
   logic               same_low;
   logic               same_high;
   logic        [15:0] idx;
   logic               mapped;
   logic        [7:0]  rd_byte;
   logic        [7:0]  wbyte;
   logic               wr_go;
   logic               standby;

   ////////////////////////////////////////////////////////////////////////////////
   // Trigger selection and transfer

   assign standby    = s_q.standby_sync[1];
   assign enable_all = {s_q.en_high, s_q.en_low};
   assign stage_all  = {s_q.stage_high, s_q.stage_low};
   assign latch_all  = {s_q.phigh_latch, s_q.plow_latch};
   assign same_low   = (s_q.trig[3:2] == s_q.trig[1:0]);
   assign same_high  = (s_q.trig[7:6] == s_q.trig[5:4]);

   always_comb begin
      for (int g = 0; g < 4; g++) begin
         // Code 11 selects channel 3
         fire_a[g] = cmp_a[s_q.trig[g*`TRIG_FIELD_W +: `TRIG_FIELD_W]];  // [R4] [R19]
         fire_b[g] = cmp_b[s_q.trig[g*`TRIG_FIELD_W +: `TRIG_FIELD_W]];  // [R4]
      end
   end

   always_comb begin
      latch_next = latch_all;
      for (int i = 0; i < 16; i++) begin
         if (enable_all[i] && fire_a[i/4]) begin
            // Whole group copies in one edge, shared triggers in the same edge
            latch_next[i] = stage_all[i];  // [R1] [R3] [R12] [R20] [R21]
         end else if (enable_all[i] && s_q.mode[i/4] && fire_b[i/4] && !stage_all[i]) begin
            // Falling bits go early; rising ones wait for the A event
            latch_next[i] = 1'b0;  // [R5]
         end
      end
   end  // Disabled bits keep their value [R18]

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode and read mux

   assign idx    = paddr[17:2];
   assign wbyte  = pwdata[7:0];
   assign wr_go  = psel && penable && pwrite && (s_q.phase == tpc_pkg::PH_DONE) && mapped;

   always_comb begin
      mapped  = 1'b1;
      rd_byte = `RST_ZERO;
      unique case (idx)
         `IDX_MODE:          rd_byte = s_q.mode;
         `IDX_TRIG:          rd_byte = s_q.trig;
         `IDX_EN_HIGH:       rd_byte = s_q.en_high;
         `IDX_EN_LOW:        rd_byte = s_q.en_low;
         `IDX_STAGE_HIGH:    rd_byte = same_high ? s_q.stage_high
                                                 : {s_q.stage_high[7:4], `NIB_ONES};  // [R17]
         `IDX_STAGE_LOW:     rd_byte = same_low ? s_q.stage_low
                                                : {s_q.stage_low[7:4], `NIB_ONES};  // [R14] [R16]
         `IDX_STAGE_HIGH_G2: rd_byte = same_high ? `RD_ONES
                                                 : {`NIB_ONES, s_q.stage_high[3:0]};  // [R17]
         `IDX_STAGE_LOW_G0:  rd_byte = same_low ? `RD_ONES
                                                : {`NIB_ONES, s_q.stage_low[3:0]};  // [R15] [R16]
         // Direction registers cannot be read back
         `IDX_PLOW_DIR:      rd_byte = `RD_ONES;  // [R6]
         `IDX_PLOW_LATCH:    rd_byte = s_q.plow_latch;
         `IDX_PHIGH_DIR:     rd_byte = `RD_ONES;  // [R6] [R8]
         `IDX_PHIGH_LATCH:   rd_byte = s_q.phigh_latch;
         default:            mapped  = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d = s_q;
      s_d.standby_sync = {s_q.standby_sync[0], hw_standby};

      // APB: one wait cycle so read data and pready come from flops
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.phase   = tpc_pkg::PH_WAIT;
      if (psel && penable && (s_q.phase == tpc_pkg::PH_WAIT)) begin
         s_d.phase   = tpc_pkg::PH_DONE;
         s_d.pready  = 1'b1;
         s_d.pslverr = !mapped;
         s_d.prdata  = (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end

      // Pattern transfer into the port latches
      s_d.plow_latch  = latch_next[7:0];  // [R9] [R12]
      s_d.phigh_latch = latch_next[15:8];  // [R9]

      if (wr_go) begin
         unique case (idx)
            `IDX_MODE:          s_d.mode = {`NIB_ONES, wbyte[`MODE_NOV_MSB:0]};
            `IDX_TRIG:          s_d.trig = wbyte;
            `IDX_EN_HIGH:       s_d.en_high = wbyte;
            `IDX_EN_LOW:        s_d.en_low = wbyte;
            `IDX_STAGE_HIGH: begin
               if (same_high) begin
                  s_d.stage_high = wbyte;  // [R17]
               end else begin
                  s_d.stage_high[7:4] = wbyte[7:4];  // [R17]
               end
            end
            `IDX_STAGE_LOW: begin
               if (same_low) begin
                  s_d.stage_low = wbyte;  // [R14]
               end else begin
                  s_d.stage_low[7:4] = wbyte[7:4];  // [R16]
               end
            end
            `IDX_STAGE_HIGH_G2: begin
               if (!same_high) begin
                  s_d.stage_high[3:0] = wbyte[3:0];  // [R17]
               end
            end
            `IDX_STAGE_LOW_G0: begin
               // Reserved when triggers are shared
               if (!same_low) begin
                  s_d.stage_low[3:0] = wbyte[3:0];  // [R15] [R16]
               end
            end
            `IDX_PLOW_DIR:      s_d.plow_dir = wbyte;  // [R6]
            `IDX_PLOW_LATCH: begin
               // CPU reaches only bits not used for pattern output
               s_d.plow_latch = (latch_next[7:0] & s_q.en_low)
                              | (wbyte & ~s_q.en_low);  // [R10]
            end
            `IDX_PHIGH_DIR:     s_d.phigh_dir = wbyte;  // [R8]
            `IDX_PHIGH_LATCH: begin
               s_d.phigh_latch = (latch_next[15:8] & s_q.en_high)
                               | (wbyte & ~s_q.en_high);  // [R11]
            end
            default: begin
            end
         endcase
      end

      // Pin drive follows direction; pattern bit 14 never leaves the chip
      s_d.plow_oe  = s_d.plow_dir;  // [R7]
      s_d.phigh_oe = s_d.phigh_dir;
      if (s_d.en_high[`PATTERN_HOLE]) begin
         s_d.phigh_oe[`PATTERN_HOLE] = 1'b0;  // [R2]
      end

      // Hardware standby clears the registers and latches like reset, but not the APB state, and floats the pins
      if (standby) begin
         s_d.mode        = `RST_MODE;
         s_d.trig        = `RST_TRIG;
         s_d.en_high     = `RST_ZERO;
         s_d.en_low      = `RST_ZERO;
         s_d.stage_high  = `RST_ZERO;
         s_d.stage_low   = `RST_ZERO;  // [R13]
         s_d.plow_dir    = `RST_ZERO;
         s_d.phigh_dir   = `RST_ZERO;
         s_d.plow_latch  = `RST_ZERO;
         s_d.phigh_latch = `RST_ZERO;
         s_d.plow_oe     = `RST_ZERO;
         s_d.phigh_oe    = `RST_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q.standby_sync <= 2'b00;
         s_q.mode         <= `RST_MODE;
         s_q.trig         <= `RST_TRIG;
         s_q.en_high      <= `RST_ZERO;
         s_q.en_low       <= `RST_ZERO;
         s_q.stage_high   <= `RST_ZERO;
         s_q.stage_low    <= `RST_ZERO;  // [R13]
         s_q.plow_dir     <= `RST_ZERO;
         s_q.plow_latch   <= `RST_ZERO;
         s_q.phigh_dir    <= `RST_ZERO;
         s_q.phigh_latch  <= `RST_ZERO;
         s_q.phase        <= tpc_pkg::PH_WAIT;
         s_q.pready       <= 1'b0;
         s_q.pslverr      <= 1'b0;
         s_q.prdata       <= 32'h0000_0000;
         s_q.plow_oe      <= `RST_ZERO;
         s_q.phigh_oe     <= `RST_ZERO;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata        = s_q.prdata;
   assign pready        = s_q.pready;
   assign pslverr       = s_q.pslverr;
   assign port_low_out  = s_q.plow_latch;
   assign port_low_oe   = s_q.plow_oe;
   assign port_high_out = s_q.phigh_latch;
   assign port_high_oe  = s_q.phigh_oe;

endmodule : timing_pattern_output

/* File: tb/timing_pattern_output_monitor.sv */
// Port checker for the timing pattern output controller
`timescale 1ns/100ps
module timing_pattern_output_monitor (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Timer and standby
   input wire logic [3:0]  cmp_a,
   input wire logic [3:0]  cmp_b,
   input wire logic        hw_standby,
   // Port pins
   input wire logic [7:0]  port_low_out,
   input wire logic [7:0]  port_low_oe,
   input wire logic [7:0]  port_high_out,
   input wire logic [7:0]  port_high_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   a_ready_wait: assert property (psel && !penable |-> ##2 pready)
      else $error("pready not on second access cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("pslverr without pready or with data");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !pready && port_low_out == 8'h00 && port_high_out == 8'h00)
      else $error("outputs not cleared by reset");
   // Standby clears outputs, so hold checks pause while it is raised
   a_out_hold: assert property (disable iff (rst || hw_standby)
      cmp_a == 4'h0 && cmp_b == 4'h0 && !(pready && pwrite) |=> $stable({port_low_out, port_high_out}))
      else $error("port output moved without cause");
   a_oe_hold: assert property (disable iff (rst || hw_standby)
      !(pready && pwrite) |=> $stable({port_low_oe, port_high_oe}))
      else $error("drive enable moved without write");
   c_refused: cover property (pslverr);
   c_transfer: cover property (cmp_a != 4'h0 ##1 $changed(port_low_out));
   c_standby: cover property (hw_standby);
endmodule : timing_pattern_output_monitor

bind timing_pattern_output timing_pattern_output_monitor i_timing_pattern_output_monitor (
   .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_a(cmp_a),
   .cmp_b(cmp_b), .hw_standby(hw_standby), .port_low_out(port_low_out), .port_low_oe(port_low_oe),
   .port_high_out(port_high_out), .port_high_oe(port_high_oe));

/* File: tb/pattern_load.sv */
// Pull-down loads on the pattern output pins
`timescale 1ns/100ps
module pattern_load (
   // Driven side
   input  wire logic [15:0] drv,
   input  wire logic [15:0] en,
   // Level seen by the loads
   output logic      [15:0] pin
);
   // Undriven pins sit at the pull-down level; bit 14 has no pin
   assign pin = drv & en & 16'hBFFF;
endmodule : pattern_load

/* File: tb/timing_pattern_output_tb_top.sv */
// Self-checking bench for the timing pattern output controller
`timescale 1ns/100ps
`include "tpc_map.svh"
module timing_pattern_output_tb_top;
   logic        mclk       = 1'b0;
   logic        rst        = 1'b1;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [17:0] paddr      = 18'h0_0000;
   logic [31:0] pwdata     = 32'h0000_0000;
   logic [3:0]  cmp_a      = 4'h0;
   logic [3:0]  cmp_b      = 4'h0;
   logic        hw_standby = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  lo;
   logic [7:0]  lo_oe;
   logic [7:0]  hi;
   logic [7:0]  hi_oe;
   logic [15:0] pins;
   logic [31:0] rdat;
   logic        err;
   int          n_mismatch  = 0;
   int          checks_done = 0;
   int          cyc         = 0;

   always #10 mclk = ~mclk;

   timing_pattern_output i_timing_pattern_output (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmp_a(cmp_a), .cmp_b(cmp_b), .hw_standby(hw_standby),
      .port_low_out(lo), .port_low_oe(lo_oe), .port_high_out(hi), .port_high_oe(hi_oe));
   pattern_load i_pattern_load (.drv({hi, lo}), .en({hi_oe, lo_oe}), .pin(pins));

   ////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   // Waits on pready with no fixed latency; the cycle limit cuts a hang
   task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {i, 2'b00};
      pwdata  <= {24'h00_0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // The write lands on the pready edge; wait one more edge so outputs show it
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      apb(1'b1, i, d);
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [15:0] i, input logic [7:0] e);
      apb(1'b0, i, 8'h00);
      chk(rdat, {24'h00_0000, e});
   endtask : rd

   task automatic pulse(input logic [3:0] a, input logic [3:0] b);
      @(posedge mclk);
      cmp_a <= a;
      cmp_b <= b;
      @(posedge mclk);
      cmp_a <= 4'h0;
      cmp_b <= 4'h0;
      @(posedge mclk);
   endtask : pulse

   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(`IDX_MODE, `RST_MODE);
      rd(`IDX_TRIG, `RST_TRIG);
      rd(`IDX_STAGE_LOW, `RST_ZERO);
      rd(`IDX_PHIGH_DIR, `RD_ONES);
      apb(1'b0, 16'h0123, 8'h00);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      wr(`IDX_MODE, 8'h0F);
      rd(`IDX_MODE, 8'hFF);
   endtask : t_reset

   task automatic t_low;
      wr(`IDX_PLOW_DIR, 8'hFF);
      wr(`IDX_PLOW_LATCH, 8'h3C);
      wr(`IDX_EN_LOW, 8'h0F);
      wr(`IDX_STAGE_LOW, 8'hA5);
      pulse(4'h0, 4'h8);
      chk(lo, 8'h34);
      pulse(4'h8, 4'h0);
      chk(lo, 8'h35);
      wr(`IDX_PLOW_LATCH, 8'hF0);
      chk(lo, 8'hF5);
      chk(pins[7:0], 8'hF5);
   endtask : t_low

   task automatic t_split;
      wr(`IDX_TRIG, 8'hA4);
      wr(`IDX_EN_LOW, 8'hFF);
      wr(`IDX_STAGE_LOW, 8'h3F);
      wr(`IDX_STAGE_LOW_G0, 8'h0C);
      rd(`IDX_STAGE_LOW, 8'h3F);
      rd(`IDX_STAGE_LOW_G0, 8'hFC);
      pulse(4'h1, 4'h0);
      chk(lo, 8'hFC);
      pulse(4'h2, 4'h0);
      chk(lo, 8'h3C);
   endtask : t_split

   task automatic t_high;
      wr(`IDX_PHIGH_DIR, 8'hFF);
      wr(`IDX_EN_HIGH, 8'hFF);
      wr(`IDX_STAGE_HIGH, 8'h5A);
      wr(`IDX_STAGE_HIGH_G2, 8'h00);
      rd(`IDX_STAGE_HIGH_G2, 8'hFF);
      pulse(4'h4, 4'h0);
      chk({hi, lo}, 16'h5A3C);
      chk(hi_oe, 8'hBF);
      wr(`IDX_PHIGH_LATCH, 8'h00);
      chk(hi, 8'h5A);
   endtask : t_high

   task automatic t_shared;
      wr(`IDX_TRIG, 8'h00);
      wr(`IDX_STAGE_LOW, 8'h96);
      wr(`IDX_STAGE_HIGH, 8'hC3);
      rd(`IDX_STAGE_LOW_G0, 8'hFF);
      pulse(4'h1, 4'h0);
      chk({hi, lo}, 16'hC396);
   endtask : t_shared

   task automatic t_standby;
      @(posedge mclk);
      hw_standby <= 1'b1;
      repeat (5) @(posedge mclk);
      hw_standby <= 1'b0;
      repeat (4) @(posedge mclk);
      chk({hi, lo}, 16'h0000);
      rd(`IDX_STAGE_LOW, `RST_ZERO);
   endtask : t_standby

   ////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         end_sim();
      end
   end

   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_low();
      t_split();
      t_high();
      t_shared();
      t_standby();
      end_sim();
   end
endmodule : timing_pattern_output_tb_top
